// [include/cc_pkg.sv]
// Function
// - three modules share one 16-bit counter reference
// - each module picks its mode on its own
// - rise/fall enable bits pick capture edges
// - capture copies counter into module value
// - capture sets flag; enabled flag requests interrupt
// - flag stays set until software clears it
// - flag enable gated by global and array enables
// - software timer sets flag on counter equality
// - low write clears compare enable, high sets
// - high-speed output inverts pin on every match except in its entry cycle
// - toggle output starts and restarts at one
// - frequency mode: compare, toggle, pwm bits set
// - low-byte match toggles pin, adds high byte
// - high byte zero counts as 256 half-period
// - 8-bit pwm: compare, pwm set, wide clear
// - low-byte match sets pin, overflow clears
// - low byte overflow reloads low from high
// - compare enable clear holds pwm output low
// - 16-bit pwm: compare, pwm and wide set
// - 16-bit match sets pin, overflow clears it
// - flags sit at bits two, one, zero
package cc_pkg;

   // ==========================================================
   // sizes
   localparam int N_MODULES = 3;
   localparam int CNT_W = 16;
   localparam int BYTE_W = 8;

   // ==========================================================
   // mode register field positions
   localparam int MODE_WIDE_PWM = 7;
   localparam int MODE_CMP_EN = 6;
   localparam int MODE_RISE = 5;
   localparam int MODE_FALL = 4;
   localparam int MODE_MATCH = 3;
   localparam int MODE_TOGGLE = 2;
   localparam int MODE_PWM = 1;
   localparam int MODE_IRQ_EN = 0;

   // ==========================================================
   // reset values and counter landmarks
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [15:0] CMP_RST = 16'h0000;
   localparam logic PIN_RST = 1'b1;
   localparam logic TOGGLE_INIT = 1'b1;
   localparam logic [7:0] LOW_ZERO = 8'h00;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   typedef enum logic [6:0] {
      MODE_OFF = 7'b000_0001,
      MODE_CAPTURE = 7'b000_0010,
      MODE_SW_TIMER = 7'b000_0100,
      MODE_HS_OUT = 7'b000_1000,
      MODE_FREQ = 7'b001_0000,
      MODE_PWM8 = 7'b010_0000,
      MODE_PWM16 = 7'b100_0000
   } cc_mode_e;

   function automatic cc_mode_e mode_decode(input logic [7:0] m);
      logic caps;
      caps = m[MODE_RISE] | m[MODE_FALL];
      if (caps && !m[MODE_MATCH] && !m[MODE_TOGGLE] && !m[MODE_PWM]) begin
         mode_decode = MODE_CAPTURE;
      end else if (caps || !m[MODE_CMP_EN]) begin
         mode_decode = MODE_OFF;
      end else if (m[MODE_PWM] && m[MODE_TOGGLE]) begin
         mode_decode = MODE_FREQ;
      end else if (m[MODE_PWM]) begin
         mode_decode = m[MODE_WIDE_PWM] ? MODE_PWM16 : MODE_PWM8;
      end else if (m[MODE_MATCH]) begin
         mode_decode = m[MODE_TOGGLE] ? MODE_HS_OUT : MODE_SW_TIMER;
      end else begin
         mode_decode = MODE_OFF;
      end
   endfunction

endpackage

// [include/cc_sync_if.sv]
`timescale 1ns/1ps
interface cc_sync_if #(
   parameter int N = 3
);
   logic [N-1:0] pin_raw;
   logic [N-1:0] rise;
   logic [N-1:0] fall;

   modport sync_side (
      input pin_raw,
      output rise,
      output fall
   );

   modport core_side (
      output pin_raw,
      input rise,
      input fall
   );
endinterface

// [hw/cc_pin_sync.sv]
`timescale 1ns/1ps
module cc_pin_sync #(
   parameter int N = 3
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // pins in, edges out
   cc_sync_if.sync_side sif
);

   typedef struct packed {
      logic [N-1:0] meta;
      logic [N-1:0] stable;
      logic [N-1:0] last;
      logic [1:0] primed;
   } sync_s;

   sync_s sync_ff;
   sync_s nxt_sync;

   // ==========================================================
   // synchroniser and edge detector
   always_comb begin
      nxt_sync = sync_ff;
      nxt_sync.meta = sif.pin_raw;
      nxt_sync.stable = sync_ff.meta;
      nxt_sync.last = sync_ff.stable;
      nxt_sync.primed = {sync_ff.primed[0], 1'b1};
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   // no edges until the stable stage holds real pin data; last may still hold its reset zero
   assign sif.rise = sync_ff.stable & ~sync_ff.last & {N{sync_ff.primed[1]}};
   assign sif.fall = ~sync_ff.stable & sync_ff.last & {N{sync_ff.primed[1]}};

endmodule

// [hw/cc_array.sv]
`timescale 1ns/1ps
module cc_array #(
   parameter int N = cc_pkg::N_MODULES,
   parameter int CW = cc_pkg::CNT_W
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,

   // shared counter
   input wire logic [CW-1:0] counter_value_i,
   input wire logic counter_tick_i,

   // cpu writes
   input wire logic [N-1:0] mode_wr_i,
   input wire logic [N-1:0] cmp_low_wr_i,
   input wire logic [N-1:0] cmp_high_wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [N-1:0] flag_clr_i,

   // interrupt enables
   input wire logic global_irq_en_i,
   input wire logic array_irq_en_i,

   // module pins
   input wire logic [N-1:0] module_pin_i,
   output logic [N-1:0] module_pin_o,
   output logic [N-1:0] module_pin_oe_n_o,

   // cpu reads
   output logic [N-1:0][7:0] module_mode_reg_o,
   output logic [N-1:0][CW-1:0] module_cmp_value_o,
   output logic [N-1:0] module_event_flag_o,
   output logic irq_o
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [N-1:0][7:0] mode;
      logic [N-1:0][CW-1:0] cmp;
      logic [N-1:0] flag;
      logic [N-1:0] pin;
      logic [N-1:0] drive;
      logic [N-1:0] in_hs_out;
   } cc_state_s;

   cc_state_s state_ff;
   cc_state_s nxt_state;

   // ==========================================================
   // pin synchroniser
   cc_sync_if #(.N(N)) sync_bus ();

   assign sync_bus.pin_raw = module_pin_i;

   cc_pin_sync #(
      .N(N)
   ) u_pin_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .sif(sync_bus.sync_side)
   );

   // ==========================================================
   // helpers
   function automatic logic eq_full(
      input logic tick,
      input logic [CW-1:0] a,
      input logic [CW-1:0] b
   );
      eq_full = tick && (a == b);
   endfunction

   function automatic logic eq_low(
      input logic tick,
      input logic [7:0] a,
      input logic [7:0] b
   );
      eq_low = tick && (a == b);
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      cc_pkg::cc_mode_e mode_now;
      logic [7:0] m;
      logic [7:0] cmp_lo;
      logic [7:0] cmp_hi;
      logic [7:0] cnt_lo;
      logic hit_full;
      logic hit_low;
      logic ovf_low;
      logic ovf_full;
      logic cap_edge;
      logic set_flag;

      nxt_state = state_ff;
      mode_now = cc_pkg::MODE_OFF;
      m = cc_pkg::MODE_RST;
      cmp_lo = cc_pkg::LOW_ZERO;
      cmp_hi = cc_pkg::LOW_ZERO;
      cnt_lo = counter_value_i[7:0];
      hit_full = 1'b0;
      hit_low = 1'b0;
      ovf_low = 1'b0;
      ovf_full = 1'b0;
      cap_edge = 1'b0;
      set_flag = 1'b0;

      // each module runs on its own mode bits
      for (int i = 0; i < N; i++) begin
         m = state_ff.mode[i];
         mode_now = cc_pkg::mode_decode(m);
         cmp_lo = state_ff.cmp[i][7:0];
         cmp_hi = state_ff.cmp[i][15:8];
         hit_full = eq_full(counter_tick_i, counter_value_i, state_ff.cmp[i]);
         hit_low = eq_low(counter_tick_i, cnt_lo, cmp_lo);
         ovf_low = eq_low(counter_tick_i, cnt_lo, cc_pkg::LOW_ZERO);
         ovf_full = eq_full(counter_tick_i, counter_value_i, cc_pkg::CNT_ZERO);
         cap_edge = (m[cc_pkg::MODE_RISE] & sync_bus.rise[i])
                  | (m[cc_pkg::MODE_FALL] & sync_bus.fall[i]);
         set_flag = 1'b0;
         nxt_state.in_hs_out[i] = (mode_now == cc_pkg::MODE_HS_OUT);
         nxt_state.drive[i] = 1'b1;

         case (mode_now)
            cc_pkg::MODE_CAPTURE: begin
               nxt_state.drive[i] = 1'b0;
               if (cap_edge) begin
                  nxt_state.cmp[i] = counter_value_i;
                  set_flag = 1'b1;
               end
            end
            cc_pkg::MODE_SW_TIMER: begin
               if (hit_full) begin
                  set_flag = 1'b1;
               end
            end
            cc_pkg::MODE_HS_OUT: begin
               if (!state_ff.in_hs_out[i]) begin
                  nxt_state.pin[i] = cc_pkg::TOGGLE_INIT;
               end else if (hit_full) begin
                  nxt_state.pin[i] = ~state_ff.pin[i];
                  set_flag = 1'b1;
               end
            end
            cc_pkg::MODE_FREQ: begin
               if (hit_low) begin
                  nxt_state.pin[i] = ~state_ff.pin[i];
                  // 8-bit wrap makes a zero step a full 256 count
                  nxt_state.cmp[i][7:0] = 8'(cmp_lo + cmp_hi);
                  set_flag = m[cc_pkg::MODE_MATCH];
               end
            end
            cc_pkg::MODE_PWM8: begin
               if (ovf_low) begin
                  nxt_state.pin[i] = 1'b0;
                  nxt_state.cmp[i][7:0] = cmp_hi;
               end
               // set wins over reset so a zero high byte gives full duty
               if (hit_low) begin
                  nxt_state.pin[i] = 1'b1;
                  set_flag = m[cc_pkg::MODE_MATCH];
               end
            end
            cc_pkg::MODE_PWM16: begin
               if (ovf_full) begin
                  nxt_state.pin[i] = 1'b0;
               end
               if (hit_full) begin
                  nxt_state.pin[i] = 1'b1;
                  set_flag = m[cc_pkg::MODE_MATCH];
               end
            end
            cc_pkg::MODE_OFF: begin
               // pwm with compare disabled means zero duty
               if (m[cc_pkg::MODE_PWM] && !m[cc_pkg::MODE_TOGGLE]
                   && !m[cc_pkg::MODE_RISE] && !m[cc_pkg::MODE_FALL]) begin
                  nxt_state.pin[i] = 1'b0;
               end else begin
                  nxt_state.drive[i] = 1'b0;
               end
            end
            default: begin
               nxt_state.drive[i] = 1'b0;
            end
         endcase

         // cpu byte writes beat the hardware update of the same byte
         if (mode_wr_i[i]) begin
            nxt_state.mode[i] = wdata_i;
         end
         if (cmp_low_wr_i[i]) begin
            nxt_state.cmp[i][7:0] = wdata_i;
            nxt_state.mode[i][cc_pkg::MODE_CMP_EN] = 1'b0;
         end
         if (cmp_high_wr_i[i]) begin
            nxt_state.cmp[i][15:8] = wdata_i;
            nxt_state.mode[i][cc_pkg::MODE_CMP_EN] = 1'b1;
         end

         // a new event beats a clear in the same cycle
         nxt_state.flag[i] = set_flag | (state_ff.flag[i] & ~flag_clr_i[i]);
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_ff.mode <= {N{cc_pkg::MODE_RST}};
         state_ff.cmp <= {N{cc_pkg::CMP_RST}};
         state_ff.flag <= '0;
         state_ff.pin <= {N{cc_pkg::PIN_RST}};
         state_ff.drive <= '0;
         state_ff.in_hs_out <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // outputs
   assign module_pin_o = state_ff.pin;
   // oe is active low: drive in every compare mode, software timer included, and in compare-disabled pwm
   assign module_pin_oe_n_o = ~state_ff.drive;
   assign module_mode_reg_o = state_ff.mode;
   assign module_cmp_value_o = state_ff.cmp;
   assign module_event_flag_o = state_ff.flag;

   always_comb begin
      logic any_req;
      any_req = 1'b0;
      for (int i = 0; i < N; i++) begin
         any_req = any_req | (state_ff.flag[i] & state_ff.mode[i][cc_pkg::MODE_IRQ_EN]);
      end
      irq_o = any_req & global_irq_en_i & array_irq_en_i;
   end

endmodule

// [bench/cc_pin_model.sv]
`timescale 1ns/1ps
module cc_pin_model #(
   parameter int N = 3
) (
   // clock and requested levels
   input wire logic ref_clk_i,
   input wire logic [N-1:0] want_i,
   // pin levels
   output logic [N-1:0] pin_o
);
   // ====================
   // source
   int held [N];
   initial begin
      pin_o = '0;
      for (int i = 0; i < N; i++) held[i] = 2;
   end
   // a level is given up only after it stood two cycles
   always @(negedge ref_clk_i) begin
      for (int i = 0; i < N; i++) begin
         if (want_i[i] != pin_o[i] && held[i] >= 2) begin
            pin_o[i] <= want_i[i];
            held[i] = 1;
         end else begin
            held[i] = held[i] + 1;
         end
      end
   end
endmodule

// [bench/cc_array_chk.sv]
`timescale 1ns/1ps
module cc_array_chk #(
   parameter int N = 3,
   parameter int CW = 16
) (
   // clock, reset, stimulus
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [CW-1:0] counter_value_i,
   input wire logic counter_tick_i,
   input wire logic [N-1:0] cmp_low_wr_i,
   input wire logic [N-1:0] cmp_high_wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [N-1:0] flag_clr_i,
   input wire logic global_irq_en_i,
   input wire logic array_irq_en_i,
   // observed
   input wire logic [N-1:0] module_pin_o,
   input wire logic [N-1:0][7:0] module_mode_reg_o,
   input wire logic [N-1:0][CW-1:0] module_cmp_value_o,
   input wire logic [N-1:0] module_event_flag_o,
   input wire logic irq_o
);
   // ====================
   // helpers, mode and match of module 0 only to keep this cheap; ien covers all modules
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [N-1:0] ien;
   logic [7:0] m0;
   logic hit0;
   always_comb begin
      for (int i = 0; i < N; i++) ien[i] = module_mode_reg_o[i][0];
   end
   assign m0 = module_mode_reg_o[0];
   assign hit0 = counter_tick_i && counter_value_i == module_cmp_value_o[0];
   // ====================
   // properties
   a_irq_gating:
      assert property (irq_o == (global_irq_en_i && array_irq_en_i
         && |(module_event_flag_o & ien))) else $error("irq wrong");
   a_flag_sticky:
      assert property (&(~$past(module_event_flag_o) | module_event_flag_o
         | $past(flag_clr_i))) else $error("flag dropped");
   a_low_wr_clears:
      assert property (cmp_low_wr_i[0] && !cmp_high_wr_i[0] |=> !m0[6]
         && module_cmp_value_o[0][7:0] == $past(wdata_i)) else $error("low write");
   a_high_wr_sets:
      assert property (cmp_high_wr_i[0] |=> m0[6]
         && module_cmp_value_o[0][15:8] == $past(wdata_i)) else $error("high write");
   a_timer_flag:
      assert property (m0[6:1] == 6'b10_0100 && hit0 |=> module_event_flag_o[0])
      else $error("timer flag");
   a_hs_toggle:
      assert property (m0[6:1] == 6'b10_0110 && $stable(m0) && hit0
         |=> module_pin_o[0] != $past(module_pin_o[0])) else $error("no toggle");
   a_hs_init:
      assert property (m0[6:1] == 6'b10_0110 && $past(m0[6:1]) != 6'b10_0110
         |=> module_pin_o[0]) else $error("toggle init");
   a_pwm16_high:
      assert property (m0[7:4] == 4'b1100 && m0[2:1] == 2'b01 && hit0
         |=> module_pin_o[0]) else $error("pwm16 set");
   c_hs: cover property (m0[6:1] == 6'b10_0110 && hit0);
   c_irq: cover property (irq_o);
   c_pwm16: cover property (m0[7:4] == 4'b1100 && hit0);
endmodule

bind cc_array cc_array_chk #(.N(N), .CW(CW)) i_cc_array_chk (.ref_clk_i, .rst_n_i,
   .counter_value_i, .counter_tick_i, .cmp_low_wr_i, .cmp_high_wr_i, .wdata_i,
   .flag_clr_i, .global_irq_en_i, .array_irq_en_i, .module_pin_o, .module_mode_reg_o,
   .module_cmp_value_o, .module_event_flag_o, .irq_o);

// [bench/cc_array_tb.sv]
`timescale 1ns/1ps
module cc_array_tb;
   localparam int N = 3;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, counter_tick_i = 1'b0, irq_o;
   logic global_irq_en_i = 1'b0, array_irq_en_i = 1'b0;
   logic [15:0] counter_value_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00;
   logic [N-1:0] mode_wr_i = '0, cmp_low_wr_i = '0, cmp_high_wr_i = '0, flag_clr_i = '0;
   logic [N-1:0] want = '0, mdl_pin, pin_w, pin_o, oe_n, flag_o;
   logic [N-1:0][7:0] mode_o;
   logic [N-1:0][15:0] val_o;
   int em [N], ev [N], ep [N], ef [N];
   int fail_count = 0, compares = 0;
   always #10 ref_clk_i = ~ref_clk_i;
   assign pin_w = (~oe_n & pin_o) | (oe_n & mdl_pin);
   cc_pin_model #(.N(N)) i_cc_pin_model (.ref_clk_i(ref_clk_i), .want_i(want),
      .pin_o(mdl_pin));
   cc_array i_cc_array (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .counter_value_i(counter_value_i), .counter_tick_i(counter_tick_i),
      .mode_wr_i(mode_wr_i), .cmp_low_wr_i(cmp_low_wr_i), .cmp_high_wr_i(cmp_high_wr_i),
      .wdata_i(wdata_i), .flag_clr_i(flag_clr_i), .global_irq_en_i(global_irq_en_i),
      .array_irq_en_i(array_irq_en_i), .module_pin_i(pin_w), .module_pin_o(pin_o),
      .module_pin_oe_n_o(oe_n), .module_mode_reg_o(mode_o), .module_cmp_value_o(val_o),
      .module_event_flag_o(flag_o), .irq_o(irq_o));
   // ====================
   // checking
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp_all;
      int r;
      r = 0;
      for (int i = 0; i < N; i++) begin
         r |= ef[i] & em[i];
         chk("mode", 16'(mode_o[i]), em[i]);
         chk("value", val_o[i], ev[i]);
         chk("pin", 16'(pin_o[i]), ep[i]);
         chk("flag", 16'(flag_o[i]), ef[i]);
      end
      chk("irq", 16'(irq_o), r & global_irq_en_i & array_irq_en_i);
   endtask
   // ====================
   // stimulus and reference model
   task automatic wr(input int i, wk, input logic [7:0] d);
      int o;
      o = em[i];
      wdata_i = d;
      if (wk == 0) begin mode_wr_i[i] = 1'b1; em[i] = d; end
      else if (wk == 1) begin cmp_low_wr_i[i] = 1'b1; ev[i] = ev[i] & 65280 | d; em[i] &= 191; end
      else begin cmp_high_wr_i[i] = 1'b1; ev[i] = ev[i] & 255 | d << 8; em[i] |= 64; end
      if ((em[i] >> 1 & 63) == 38 && (o >> 1 & 63) != 38) ep[i] = 1;
      if ((em[i] & 118) == 2) ep[i] = 0;
      @(negedge ref_clk_i);
      {mode_wr_i, cmp_low_wr_i, cmp_high_wr_i} = '0;
      @(negedge ref_clk_i);
   endtask
   task automatic tick(input logic [15:0] c);
      int m, v, lo, hi;
      {counter_value_i, counter_tick_i} = {c, 1'b1};
      for (int i = 0; i < N; i++) begin
         m = em[i]; v = ev[i]; lo = v & 255; hi = v >> 8;
         if ((m & 48) != 0 || (m & 64) == 0) begin
            if ((m & 118) == 2) ep[i] = 0;
         end else if ((m & 6) == 6) begin
            if (lo == c[7:0]) begin ep[i] ^= 1; ev[i] = hi << 8 | (lo + hi) & 255; ef[i] |= m >> 3 & 1; end
         end else if ((m & 130) == 130) begin
            if (c == 0) ep[i] = 0;
            if (c == v) begin ep[i] = 1; ef[i] |= m >> 3 & 1; end
         end else if (m & 2) begin
            if (c[7:0] == 0) begin ep[i] = 0; ev[i] = hi << 8 | hi; end
            if (c[7:0] == lo) begin ep[i] = 1; ef[i] |= m >> 3 & 1; end
         end else if ((m & 8) && c == v) begin ef[i] = 1; ep[i] ^= m >> 2 & 1; end
      end
      @(negedge ref_clk_i);
      counter_tick_i = 1'b0;
      cmp_all();
   endtask
   task automatic clr(input int i);
      flag_clr_i[i] = 1'b1;
      ef[i] = 0;
      @(negedge ref_clk_i);
      flag_clr_i = '0;
      cmp_all();
   endtask
   task automatic cap(input int i, input logic l, input logic [15:0] c);
      counter_value_i = c;
      want[i] <= l;
      if ((em[i] & 14) == 0 && (l ? em[i] & 32 : em[i] & 16) != 0 && l != mdl_pin[i]) begin
         ev[i] = c; ef[i] = 1;
      end
      repeat (6) @(negedge ref_clk_i);
      cmp_all();
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fail_count++;
      wrap_up();
   end
   initial begin
      logic [15:0] d;
      logic [7:0] h;
      void'($urandom(27756));
      for (int i = 0; i < N; i++) begin em[i] = 0; ev[i] = 0; ep[i] = 1; ef[i] = 0; end
      repeat (2) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      cmp_all();
      chk("oe_n", 16'(oe_n), 16'h0007);
      for (int i = 0; i < N; i++) begin
         d = 16'($urandom) | 16'h0001;
         h = (i == 0) ? 8'h00 : 8'($urandom);
         wr(i, 1, d[7:0]); wr(i, 2, d[15:8]); wr(i, 0, 8'h49);
         tick(d - 1); tick(d); tick(d + 1);
         for (int k = 0; k < 4; k++) begin
            {global_irq_en_i, array_irq_en_i} = 2'(k);
            @(negedge ref_clk_i);
            cmp_all();
         end
         clr(i);
         wr(i, 0, 8'hC2); tick(0); tick(d); tick(0);
         wr(i, 0, 8'h4C); tick(d); tick(d); tick(d + 1);
         wr(i, 1, 8'h10); wr(i, 2, h); wr(i, 0, 8'h46);
         tick(16'h0010); tick(16'h0010 + h); tick(16'h0010 + 2 * h);
         wr(i, 0, 8'h4A); tick(16'h0100); tick({8'h01, h}); tick(16'h02FF);
         wr(i, 0, 8'h02); tick(16'h0300); tick(16'h0300 + h);
         wr(i, 0, 8'h08); tick(val_o[i]);
         clr(i);
         for (int j = 1; j < 4; j++) begin
            wr(i, 0, 8'(j << 4));
            cap(i, 1'b1, 16'($urandom)); cap(i, 1'b0, 16'($urandom));
            clr(i);
         end
      end
      wrap_up();
   end
endmodule
